// ==== logic/spi_port_pkg.sv ====
// constants, offsets and types for the byte-wide serial port
// Overview of operation
// - control bit 0: 0 slave, 1 master
// - master mode drives three slave enables
// - select code 00/01/10 picks enable, 11 none
// - speed code divides clock by 8..64
// - serial clock independent of system divider
// - polarity bit sets clock idle level
// - receive register returns latest captured byte
// - transmit bytes queue four deep and go out in write order
// - overrun interrupt only when enable bit 2
// - data available interrupt only when bit 1
// - transmit empty interrupt only when bit 0
// - status bit 2 set on receive overwrite
// - status bit 1 set on completed transfer
// - status bit 0 high while transmit has room
// - any write to clear register clears overrun
// - unused upper register bits do nothing
package spi_port_pkg;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 4;
	localparam logic [7:0] ADDR_CONTROL = 8'hb4;
	localparam logic [7:0] ADDR_RECEIVE = 8'hb5;
	localparam logic [7:0] ADDR_TRANSMIT = 8'hb6;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hb7;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hbc;
	localparam logic [7:0] ADDR_OVERRUN_CLEAR = 8'hbd;
	// control field positions
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CTRL_POLARITY_BIT = 1;
	localparam int CTRL_SPEED_LSB = 2;
	localparam int CTRL_SELECT_LSB = 4;
	localparam int CTRL_W = 6;
	// interrupt enable and status bit positions
	localparam int IRQ_TX_EMPTY_BIT = 0;
	localparam int IRQ_RX_AVAIL_BIT = 1;
	localparam int IRQ_OVERRUN_BIT = 2;
	localparam int IRQ_W = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
	localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 3'h0;
	localparam logic [1:0] SELECT_NONE = 2'h3;
	// smallest divide ratio; each speed code step doubles it
	localparam int SCK_DIV_BASE = 8;
	localparam logic [5:0] HALF_PERIOD_BASE = 6'(SCK_DIV_BASE / 2);
	localparam logic [3:0] BITS_PER_BYTE = 4'(DATA_W);
	// synchroniser lanes of the pin inputs
	localparam int PIN_SCK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_SS = 3;
	localparam int PIN_W = 4;
	localparam logic [PIN_W-1:0] PIN_RESET = 4'h8;
	typedef enum logic [0:0] {ST_IDLE, ST_XFER} xfer_state_t;
endpackage

// ==== logic/byte_stream_if.sv ====
// valid/ready byte stream between the port core and its transmit fifo
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== logic/byte_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	byte_stream_if.sink fill,
	byte_stream_if.source drain
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic push, pop;

	// honest flags straight from the occupancy count
	assign fill.ready = (count_q != FULL_COUNT);
	assign drain.valid = (count_q != '0);
	assign drain.data = mem_q[rd_ptr_q];
	assign push = fill.valid & fill.ready;
	assign pop = drain.valid & drain.ready;

	// pointer and count update, wrapping at any depth
	always_comb begin
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push) begin
			wr_ptr_d = (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == LAST_SLOT) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end

	// storage needs no reset; empty slots are never presented
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_ptr_q] <= fill.data;
		end
	end
endmodule
`default_nettype wire

// ==== logic/spi_master_slave_port.sv ====
// byte-wide serial port core: register file, master and slave shift engine
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port
	import spi_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [spi_port_pkg::DATA_W-1:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [spi_port_pkg::DATA_W-1:0] sfr_rdata,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic slave_select_in_n,
	output logic slave_enable_0_n,
	output logic slave_enable_1_n,
	output logic slave_enable_2_n
);
	byte_stream_if #(.W(DATA_W)) tx_fill ();
	byte_stream_if #(.W(DATA_W)) tx_drain ();

	// transmit bytes queue here so software can run ahead of the wire
	byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fill(tx_fill),
		.drain(tx_drain)
	);

	// register file state
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic [IRQ_W-1:0] irq_en_q, irq_en_d;
	logic [DATA_W-1:0] receive_byte_q, receive_byte_d;
	logic rx_available_flag_q, rx_available_flag_d;
	logic rx_overrun_flag_q, rx_overrun_flag_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic irq_q, irq_d;

	// shift engine state
	xfer_state_t state_q, state_d;
	logic [DATA_W-1:0] tx_shift_q, tx_shift_d;
	logic [DATA_W-1:0] rx_shift_q, rx_shift_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [5:0] div_cnt_q, div_cnt_d;
	logic sck_q, sck_d, mosi_q, mosi_d, miso_q, miso_d;
	logic [2:0] enable_n_q, enable_n_d;
	logic sck_oe_q, sck_oe_d, mosi_oe_q, mosi_oe_d, miso_oe_q, miso_oe_d;

	// pin synchronisers: three stages, a level counts once stages two and three agree
	logic [PIN_W-1:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d;
	logic [PIN_W-1:0] pins_raw;

	logic master_mode, polarity;
	logic [1:0] speed_code, select_code;
	logic [5:0] half_period;
	logic done;
	logic [DATA_W-1:0] done_byte;
	logic pop;
	logic slave_sck_edge, slave_leading, ss_fall, ss_rise;
	logic wr_ctrl, wr_tx, wr_ien, wr_ovc, rd_rx;

	assign master_mode = ctrl_q[CTRL_MASTER_BIT];
	assign polarity = ctrl_q[CTRL_POLARITY_BIT];
	assign speed_code = ctrl_q[CTRL_SPEED_LSB +: 2];
	assign select_code = ctrl_q[CTRL_SELECT_LSB +: 2];
	// half period counted on clk_sys alone, so no system prescaler touches it
	assign half_period = HALF_PERIOD_BASE << speed_code;

	assign pins_raw = {slave_select_in_n, miso_in, mosi_in, sck_in};
	assign pin_d = (pin_q & (sync2_q ^ sync3_q)) | (sync3_q & ~(sync2_q ^ sync3_q));

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_q <= PIN_RESET;
			sync2_q <= PIN_RESET;
			sync3_q <= PIN_RESET;
			pin_q <= PIN_RESET;
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q <= pin_d;
		end
	end

	// slave-side events from the filtered pin levels
	assign slave_sck_edge = pin_d[PIN_SCK] != pin_q[PIN_SCK];
	assign slave_leading = slave_sck_edge && (pin_q[PIN_SCK] == polarity);
	assign ss_fall = pin_q[PIN_SS] && !pin_d[PIN_SS];
	assign ss_rise = !pin_q[PIN_SS] && pin_d[PIN_SS];

	// register bus decode
	assign wr_ctrl = sfr_wr && (sfr_addr == ADDR_CONTROL);
	assign wr_tx = sfr_wr && (sfr_addr == ADDR_TRANSMIT);
	assign wr_ien = sfr_wr && (sfr_addr == ADDR_IRQ_ENABLE);
	assign wr_ovc = sfr_wr && (sfr_addr == ADDR_OVERRUN_CLEAR);
	assign rd_rx = sfr_rd && (sfr_addr == ADDR_RECEIVE);

	// writes to a full queue are dropped; status bit 0 (tx_fill.ready) tells software first
	assign tx_fill.valid = wr_tx;
	assign tx_fill.data = sfr_wdata;
	assign tx_drain.ready = pop;

	// shift engine: master clocking, slave edge following, byte completion
	always_comb begin
		state_d = state_q;
		tx_shift_d = tx_shift_q;
		rx_shift_d = rx_shift_q;
		bit_cnt_d = bit_cnt_q;
		div_cnt_d = div_cnt_q;
		sck_d = sck_q;
		mosi_d = mosi_q;
		miso_d = miso_q;
		enable_n_d = 3'h7;
		pop = 1'b0;
		done = 1'b0;
		done_byte = rx_shift_q;
		// pins driven only in the matching mode
		sck_oe_d = master_mode;
		mosi_oe_d = master_mode;
		miso_oe_d = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				sck_d = polarity;
				bit_cnt_d = '0;
				div_cnt_d = '0;
				if (master_mode && tx_drain.valid) begin
					pop = 1'b1;
					tx_shift_d = tx_drain.data;
					mosi_d = tx_drain.data[DATA_W-1];
					state_d = ST_XFER;
					if (select_code != SELECT_NONE) begin
						enable_n_d = ~(3'h1 << select_code);
					end
				end else if (!master_mode && ss_fall) begin
					pop = tx_drain.valid;
					tx_shift_d = tx_drain.valid ? tx_drain.data : '0;
					miso_d = tx_drain.valid ? tx_drain.data[DATA_W-1] : 1'b0;
					state_d = ST_XFER;
				end
			end
			ST_XFER: begin
				if (master_mode) begin
					enable_n_d = enable_n_q;
					if (div_cnt_q == half_period - 6'h01) begin
						div_cnt_d = '0;
						sck_d = ~sck_q;
						if (sck_q == polarity) begin
							// leading edge samples the slave's data as soon as stages two and three agree;
							// one more register would miss the bit at the fastest divide ratio
							rx_shift_d = {rx_shift_q[DATA_W-2:0], pin_d[PIN_MISO]};
							bit_cnt_d = bit_cnt_q + 4'h1;
						end else if (bit_cnt_q == BITS_PER_BYTE) begin
							done = 1'b1;
							sck_d = polarity;
							enable_n_d = 3'h7;
							state_d = ST_IDLE;
						end else begin
							tx_shift_d = {tx_shift_q[DATA_W-2:0], 1'b0};
							mosi_d = tx_shift_q[DATA_W-2];
						end
					end else begin
						div_cnt_d = div_cnt_q + 6'h01;
					end
				end else begin
					miso_oe_d = 1'b1;
					if (ss_rise || pin_q[PIN_SS]) begin
						// deselect aborts a partial byte
						miso_oe_d = 1'b0;
						state_d = ST_IDLE;
					end else if (slave_leading) begin
						rx_shift_d = {rx_shift_q[DATA_W-2:0], pin_q[PIN_MOSI]};
						bit_cnt_d = bit_cnt_q + 4'h1;
						if (bit_cnt_q == BITS_PER_BYTE - 4'h1) begin
							done = 1'b1;
							done_byte = {rx_shift_q[DATA_W-2:0], pin_q[PIN_MOSI]};
							bit_cnt_d = '0;
							// next byte of a long frame reloads from the queue
							pop = tx_drain.valid;
							tx_shift_d = tx_drain.valid ? tx_drain.data : '0;
						end
					end else if (slave_sck_edge) begin
						if (bit_cnt_q == '0) begin
							miso_d = tx_shift_q[DATA_W-1];
						end else begin
							tx_shift_d = {tx_shift_q[DATA_W-2:0], 1'b0};
							miso_d = tx_shift_q[DATA_W-2];
						end
					end
				end
				if (master_mode != (sck_oe_q == 1'b1)) begin
					// mode flipped mid-byte: drop the byte rather than mix roles
					done = 1'b0;
					enable_n_d = 3'h7;
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			tx_shift_q <= '0;
			rx_shift_q <= '0;
			bit_cnt_q <= '0;
			div_cnt_q <= '0;
			sck_q <= 1'b0;
			mosi_q <= 1'b0;
			miso_q <= 1'b0;
			enable_n_q <= 3'h7;
			sck_oe_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tx_shift_q <= tx_shift_d;
			rx_shift_q <= rx_shift_d;
			bit_cnt_q <= bit_cnt_d;
			div_cnt_q <= div_cnt_d;
			sck_q <= sck_d;
			mosi_q <= mosi_d;
			miso_q <= miso_d;
			enable_n_q <= enable_n_d;
			sck_oe_q <= sck_oe_d;
			mosi_oe_q <= mosi_oe_d;
			miso_oe_q <= miso_oe_d;
		end
	end

	// register file: flags give set priority over any clear in the same cycle
	always_comb begin
		ctrl_d = wr_ctrl ? sfr_wdata[CTRL_W-1:0] : ctrl_q;
		irq_en_d = wr_ien ? sfr_wdata[IRQ_W-1:0] : irq_en_q;
		receive_byte_d = done ? done_byte : receive_byte_q;
		rx_available_flag_d = rx_available_flag_q && !rd_rx;
		rx_overrun_flag_d = rx_overrun_flag_q && !wr_ovc;
		if (done) begin
			rx_available_flag_d = 1'b1;
			if (rx_available_flag_q && !rd_rx) begin
				rx_overrun_flag_d = 1'b1;
			end
		end
		rdata_d = rdata_q;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_CONTROL: rdata_d = {2'h0, ctrl_q};
				ADDR_RECEIVE: rdata_d = receive_byte_q;
				ADDR_IRQ_ENABLE: rdata_d = {5'h00, irq_en_q};
				ADDR_IRQ_STATUS: rdata_d = {5'h00, rx_overrun_flag_q, rx_available_flag_q, tx_fill.ready};
				default: rdata_d = 8'h00;
			endcase
		end
		// each condition reaches the processor only through its own enable
		irq_d = (irq_en_d[IRQ_OVERRUN_BIT] && rx_overrun_flag_d)
			|| (irq_en_d[IRQ_RX_AVAIL_BIT] && rx_available_flag_d)
			|| (irq_en_d[IRQ_TX_EMPTY_BIT] && tx_fill.ready);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RESET;
			irq_en_q <= IRQ_ENABLE_RESET;
			receive_byte_q <= '0;
			rx_available_flag_q <= 1'b0;
			rx_overrun_flag_q <= 1'b0;
			rdata_q <= '0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			irq_en_q <= irq_en_d;
			receive_byte_q <= receive_byte_d;
			rx_available_flag_q <= rx_available_flag_d;
			rx_overrun_flag_q <= rx_overrun_flag_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign irq = irq_q;
	assign sck_out = sck_q;
	assign sck_oe = sck_oe_q;
	assign mosi_out = mosi_q;
	assign mosi_oe = mosi_oe_q;
	assign miso_out = miso_q;
	assign miso_oe = miso_oe_q;
	assign slave_enable_0_n = enable_n_q[0];
	assign slave_enable_1_n = enable_n_q[1];
	assign slave_enable_2_n = enable_n_q[2];
endmodule
`default_nettype wire

// ==== bench/spi_port_asserts.sv ====
// concurrent checks on the serial port's pins and register reads
`timescale 1ns/1ps
`default_nettype none
module spi_port_asserts (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic slave_enable_0_n,
	input wire logic slave_enable_1_n,
	input wire logic slave_enable_2_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [2:0] en_n;
	// the three enables seen as one group
	assign en_n = {slave_enable_2_n, slave_enable_1_n, slave_enable_0_n};
	chk_unmapped_zero:
	assert property (sfr_rd && !(sfr_addr inside {8'hb4, 8'hb5, 8'hb7, 8'hbc}) |=> sfr_rdata == 8'h00)
	else $error("unmapped read not zero");
	chk_ctrl_upper:
	assert property (sfr_rd && sfr_addr == 8'hb4 |=> sfr_rdata[7:6] == 2'h0)
	else $error("control upper bits set");
	chk_irq_upper:
	assert property (sfr_rd && sfr_addr inside {8'hb7, 8'hbc} |=> sfr_rdata[7:3] == 5'h00)
	else $error("enable or status upper bits set");
	chk_rdata_hold:
	assert property (!sfr_rd |=> $stable(sfr_rdata))
	else $error("read data moved without a read");
	chk_one_enable:
	assert property ($countones(en_n) >= 2)
	else $error("more than one enable low");
	chk_master_pins:
	assert property (sck_oe == mosi_oe)
	else $error("clock and data drive differ");
	chk_miso_quiet:
	assert property (sck_oe |-> !miso_oe)
	else $error("master drives slave data pin");
	chk_enable_master:
	assert property (en_n != 3'h7 |-> sck_oe)
	else $error("enable low outside master mode");
	// a half period is never shorter than four cycles
	chk_sck_half:
	assert property ($changed(sck_out) |=> $stable(sck_out)[*3])
	else $error("serial clock half period too short");
	chk_enable_len:
	assert property ($rose(en_n != 3'h7) |-> (en_n != 3'h7)[*8])
	else $error("enable pulse too short");
endmodule
bind spi_master_slave_port spi_port_asserts chk (.clk_sys, .sys_rst, .sfr_addr, .sfr_rd, .sfr_rdata,
	.sck_out, .sck_oe, .mosi_oe, .miso_oe, .slave_enable_0_n, .slave_enable_1_n, .slave_enable_2_n);
`default_nettype wire

// ==== bench/spi_slave_model.sv ====
// behavioural slave device on the far side of the master link
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
	input wire logic cs_n,
	input wire logic sck,
	input wire logic pol,
	input wire logic mosi,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] sh;
	logic sck_q = 1'b0;
	logic cs_q = 1'b1;
	// reacts on the link edges themselves like a real slave, so the synchronised master sees each bit in time
	always @(sck or cs_n) begin
		if (cs_q && !cs_n) begin
			sh = reply;
			miso = reply[7];
		end else if (!cs_q && cs_n) begin
			// a released line shows the inverse, so no stale bit is read
			miso = ~miso;
		end else if (!cs_n && sck != sck_q) begin
			if (sck != pol) begin
				got = {got[6:0], mosi};
			end else begin
				miso = sh[6];
				sh = {sh[6:0], 1'b0};
			end
		end
		sck_q = sck;
		cs_q = cs_n;
	end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the serial port in master and slave mode
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import spi_port_pkg::*;
	logic clk_sys, sys_rst, sfr_wr, sfr_rd, irq, sck_out, sck_oe, mosi_out, mosi_oe;
	logic miso_in, miso_out, miso_oe, e0, e1, e2, pol, en_q, sck_p, mosi_p, ss_n;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, reply, got, tx, last, s;
	logic [15:0] d;
	logic [3:0] k;
	logic [2:0] en_seen;
	int error_cnt, check_count, low_cnt, falls, n;
	logic [7:0] ra [6] = '{8'hb4, 8'hb7, 8'hbc, 8'hb6, 8'hbd, 8'hb8};
	logic [15:0] rv [6] = '{16'h0, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
	spi_master_slave_port uut (.clk_sys, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .irq,
		.sck_in(sck_p), .sck_out, .sck_oe, .mosi_in(mosi_p), .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
		.slave_select_in_n(ss_n), .slave_enable_0_n(e0), .slave_enable_1_n(e1), .slave_enable_2_n(e2));
	spi_slave_model dev (.cs_n(e0 & e1 & e2), .sck(sck_out), .pol, .mosi(mosi_out), .reply,
		.miso(miso_in), .got);
	function automatic logic [2:0] en_exp(input logic [1:0] c);
		return (c == 2'h3) ? 3'h7 : ~(3'h1 << c);
	endfunction
	function automatic logic [15:0] low_exp(input logic [1:0] s, input logic [1:0] c);
		return (c == 2'h3) ? 16'h0 : 16'(64 << s);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 d = 16'(sfr_rdata);
	endtask
	// poll status, bounded so a dead engine cannot hang the run
	task automatic wait_status(input int b);
		n = 0;
		do begin
			rd(ADDR_IRQ_STATUS);
			n++;
		end while (d[b] !== 1'b1 && n < 2000);
		if (n >= 2000)
			error_cnt++;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// which enable went low, for how long, how many bytes
	always @(posedge clk_sys) begin
		en_q <= e0 & e1 & e2;
		if (!(e0 & e1 & e2)) begin
			en_seen <= {e2, e1, e0};
			low_cnt <= low_cnt + 1;
		end
		if (en_q && !(e0 & e1 & e2))
			falls <= falls + 1;
	end
	initial begin
		#250000;
		error_cnt++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		reply = 8'h00;
		pol = 1'b0;
		sck_p = 1'b0;
		mosi_p = 1'b0;
		ss_n = 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		void'($urandom(38652));
		// writes to read-only and unmapped places must change nothing
		wr(ADDR_IRQ_STATUS, 8'hff);
		wr(8'hb8, 8'hff);
		foreach (ra[i]) begin
			rd(ra[i]);
			check(d, rv[i]);
		end
		wr(ADDR_CONTROL, 8'hfe);
		rd(ADDR_CONTROL);
		check(d, 16'h3e);
		wr(ADDR_IRQ_ENABLE, 8'hff);
		rd(ADDR_IRQ_ENABLE);
		check(d, 16'h07);
		settle();
		check(16'(irq), 16'h1);
		wr(ADDR_IRQ_ENABLE, 8'hfe);
		settle();
		check(16'(irq), 16'h0);
		// every speed and select code, random polarity and data
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			pol = 1'($urandom_range(1));
			tx = 8'($urandom);
			reply = 8'($urandom);
			en_seen = 3'h7;
			low_cnt = 0;
			wr(ADDR_CONTROL, {2'h0, k[1:0], k[3:2], pol, 1'b1});
			wr(ADDR_TRANSMIT, tx);
			wait_status(1);
			rd(ADDR_RECEIVE);
			if (k[1:0] != 2'h3) begin
				check(16'(got), 16'(tx));
				check(d, 16'(reply));
			end
			rd(ADDR_IRQ_STATUS);
			check(d, 16'h01);
			check(16'(en_seen), 16'(en_exp(k[1:0])));
			check(16'(low_cnt), low_exp(k[3:2], k[1:0]));
			check(16'(sck_out), 16'(pol));
		end
		// second byte lands on an unread one
		pol = 1'b0;
		wr(ADDR_CONTROL, 8'h01);
		reply = 8'h5a;
		wr(ADDR_TRANSMIT, 8'h11);
		wait_status(1);
		reply = 8'ha5;
		wr(ADDR_TRANSMIT, 8'h22);
		wait_status(2);
		check(d, 16'h07);
		wr(ADDR_IRQ_ENABLE, 8'h04);
		settle();
		check(16'(irq), 16'h1);
		wr(ADDR_OVERRUN_CLEAR, 8'($urandom));
		rd(ADDR_IRQ_STATUS);
		check(d, 16'h03);
		settle();
		check(16'(irq), 16'h0);
		wr(ADDR_IRQ_ENABLE, 8'h02);
		settle();
		check(16'(irq), 16'h1);
		rd(ADDR_RECEIVE);
		check(d, 16'ha5);
		settle();
		check(16'(irq), 16'h0);
		// overfill the transmit fifo while the first byte is on the wire
		falls = 0;
		for (int j = 0; j < 6; j++) begin
			tx = 8'($urandom);
			if (j == 4)
				last = tx;
			wr(ADDR_TRANSMIT, tx);
		end
		rd(ADDR_IRQ_STATUS);
		check(d, 16'h00);
		n = 0;
		while ((falls < 5 || !(e0 & e1 & e2)) && n < 2000) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (8) @(posedge clk_sys);
		check(16'(falls), 16'h5);
		check(16'(got), 16'(last));
		// slave mode: the bench plays the outside master with the port's own polarity
		pol = 1'($urandom_range(1));
		tx = 8'($urandom);
		reply = 8'($urandom);
		wr(ADDR_CONTROL, {6'h00, pol, 1'b0});
		rd(ADDR_RECEIVE);
		wr(ADDR_OVERRUN_CLEAR, 8'h00);
		wr(ADDR_TRANSMIT, tx);
		@(posedge clk_sys);
		sck_p <= pol;
		repeat (8) @(posedge clk_sys);
		ss_n <= 1'b0;
		mosi_p <= reply[7];
		repeat (8) @(posedge clk_sys);
		check(16'(miso_oe), 16'h1);
		check(16'(sck_oe), 16'h0);
		// half periods of eight cycles leave room for the three-stage pin synchronisers
		for (int i = 7; i >= 0; i--) begin
			repeat (8) @(posedge clk_sys);
			s[i] = miso_out;
			sck_p <= ~pol;
			repeat (8) @(posedge clk_sys);
			sck_p <= pol;
			mosi_p <= (i > 0) ? reply[i-1] : 1'b0;
		end
		repeat (8) @(posedge clk_sys);
		ss_n <= 1'b1;
		wait_status(1);
		check(d, 16'h03);
		rd(ADDR_RECEIVE);
		check(d, 16'(reply));
		check(16'(s), 16'(tx));
		test_done();
	end
endmodule
`default_nettype wire
